// ==== design/spr_regs.vh ====
// How it works
// - Report MAC and VLAN filter counts separately.
// - Eight-bit MAC filter enable flags, reserved zero.
// - Sixteen-bit VLAN tag enable flags, reserved zero.
// - Config bit 0 shows broadcast filter enable.
// - Config bits 1,2 show channel and transmit enable.
// - Config bit 3 global multicast filter; rest zero.
// - Link settings returned as full 32-bit word.
// - Broadcast filter settings returned as 32 bits.
// - Up to eight six-byte MAC filter values returned.
// - Up to fifteen 16-bit VLAN tag values returned.
// - Valid statistics request answered with 0x98 while clock_en is high.
// - Counters aggregate host and pass-through traffic.
// - Every statistics counter is optional.
// - Unimplemented counters read as all ones.
// - Parameters show last configured value, unsupported zero.
// - MAC values packed: unicast, multicast, mixed order.
`ifndef SPR_REGS_VH
`define SPR_REGS_VH

`define SPR_CMD_GET_PARAMS   8'h17
`define SPR_CMD_GET_STATS    8'h18
`define SPR_RSP_GET_PARAMS   8'h97
`define SPR_RSP_GET_STATS    8'h98
`define SPR_CFG_BCAST_BIT    0
`define SPR_CFG_CHAN_BIT     1
`define SPR_CFG_TX_BIT       2
`define SPR_CFG_MCAST_BIT    3
`define SPR_CFG_USED_BITS    4
`define SPR_CNT_ABSENT       32'hFFFFFFFF
`define SPR_MAX_MAC          8
`define SPR_MAX_TAG          15

`endif

// ==== design/spr_stat_count.v ====
`timescale 1ns/1ps
// ----------------------------------------------------------------------
// One statistics counter, summing two traffic sources
// ----------------------------------------------------------------------
module spr_stat_count #(
	parameter PRESENT = 1
) (
	// Clock and reset
	input  wire        clock,
	input  wire        rst,
	input  wire        clock_en,
	// Increments from host and pass-through traffic
	input  wire [15:0] host_inc,
	input  wire [15:0] pass_inc,
	// Running total
	output wire [31:0] count
);
	`include "spr_regs.vh"

	reg  [31:0] total;

	always @(posedge clock) begin
		if (rst) begin
			total <= 32'h00000000;
		end else if (clock_en) begin
			total <= total + {16'h0000, host_inc} + {16'h0000, pass_inc};
		end
	end

	// An absent counter must not read as zero, which would look like idle.
	assign count = (PRESENT != 0) ? total : `SPR_CNT_ABSENT;
endmodule // spr_stat_count

// ==== design/spr_responder.v ====
`timescale 1ns/1ps
// ----------------------------------------------------------------------
// Parameter and statistics responder
// ----------------------------------------------------------------------
module spr_responder #(
	parameter UC_COUNT  = 2,
	parameter MC_COUNT  = 2,
	parameter MX_COUNT  = 2,
	parameter TAG_COUNT = 4,
	parameter NUM_STATS = 4,
	parameter [NUM_STATS-1:0] STAT_PRESENT = 4'h7
) (
	// Clock, reset and enable
	input  wire                      clock,
	input  wire                      rst,
	input  wire                      clock_en,
	// Command from the packet parser
	input  wire                      cmd_valid,
	input  wire [7:0]                cmd_type,
	input  wire                      cmd_chk_err,
	input  wire                      cmd_id_err,
	// Live configuration from the controller
	input  wire [7:0]                addr_filter_enable_bits,
	input  wire [15:0]               tag_filter_enable_bits,
	input  wire [31:0]               link_settings,
	input  wire [31:0]               bcast_settings,
	input  wire                      bcast_filter_on,
	input  wire                      channel_on,
	input  wire                      tx_on,
	input  wire                      mcast_filter_on,
	input  wire [8*48-1:0]           mac_values,
	input  wire [15*16-1:0]          tag_values,
	// Traffic increments, one 16-bit lane per counter
	input  wire [NUM_STATS*16-1:0]   host_inc,
	input  wire [NUM_STATS*16-1:0]   pass_inc,
	// Response
	output reg                       rsp_valid,
	output reg  [7:0]                rsp_type,
	output reg  [7:0]                rsp_mac_count,
	output reg  [7:0]                rsp_tag_count,
	output reg  [7:0]                rsp_mac_flags,
	output reg  [15:0]               rsp_tag_flags,
	output reg  [31:0]               rsp_link,
	output reg  [31:0]               rsp_bcast,
	output reg  [31:0]               rsp_cfg_flags,
	output reg  [8*48-1:0]           rsp_macs,
	output reg  [15*16-1:0]          rsp_tags,
	output reg  [NUM_STATS*32-1:0]   rsp_stats
);
	`include "spr_regs.vh"

	localparam MAC_TOTAL = UC_COUNT + MC_COUNT + MX_COUNT;

	// ------------------------------------------------------------------
	// Supported-entry masks
	// ------------------------------------------------------------------
	// Bits beyond the supported filters read zero, as unsupported values.
	wire [7:0]        mac_mask;
	wire [15:0]       tag_mask;
	wire [8*48-1:0]   mac_vmask;
	wire [15*16-1:0]  tag_vmask;
	wire [NUM_STATS*32-1:0] stat_bus;

	genvar gi;
	generate
		for (gi = 0; gi < 8; gi = gi + 1) begin : g_mac
			assign mac_mask[gi] = (gi < MAC_TOTAL) ? 1'b1 : 1'b0;
			assign mac_vmask[gi*48 +: 48] = {48{mac_mask[gi]}};
		end
		for (gi = 0; gi < 16; gi = gi + 1) begin : g_tag
			assign tag_mask[gi] = (gi < TAG_COUNT) ? 1'b1 : 1'b0;
		end
		for (gi = 0; gi < 15; gi = gi + 1) begin : g_tagv
			assign tag_vmask[gi*16 +: 16] = {16{tag_mask[gi]}};
		end
		for (gi = 0; gi < NUM_STATS; gi = gi + 1) begin : g_stat
			spr_stat_count #(
				.PRESENT (STAT_PRESENT[gi])
			) u_cnt (
				.clock    (clock),
				.rst      (rst),
				.clock_en (clock_en),
				.host_inc (host_inc[gi*16 +: 16]),
				.pass_inc (pass_inc[gi*16 +: 16]),
				.count    (stat_bus[gi*32 +: 32])
			);
		end
	endgenerate

	// ------------------------------------------------------------------
	// Command decode
	// ------------------------------------------------------------------
	// Packets with checksum or identifier errors are dropped silently.
	wire cmd_ok     = cmd_valid && !cmd_chk_err && !cmd_id_err;
	wire get_params = cmd_ok && (cmd_type == `SPR_CMD_GET_PARAMS);
	wire get_stats  = cmd_ok && (cmd_type == `SPR_CMD_GET_STATS);

	// ------------------------------------------------------------------
	// Command kind
	// ------------------------------------------------------------------
	// A single type field feeds both decodes, so at most one is ever true;
	// the order below only fixes the encoding.
	localparam [1:0] KIND_NONE   = 2'b00;
	localparam [1:0] KIND_PARAMS = 2'b01;
	localparam [1:0] KIND_STATS  = 2'b10;

	reg  [1:0] cmd_kind;

	always @* begin
		if (get_params) begin
			cmd_kind = KIND_PARAMS;
		end else if (get_stats) begin
			cmd_kind = KIND_STATS;
		end else begin
			cmd_kind = KIND_NONE;
		end
	end

	// ------------------------------------------------------------------
	// Configuration flags word
	// ------------------------------------------------------------------
	// Reserved bits stay zero so a host never sees stale junk in them.
	reg  [31:0] cfg_word;

	always @* begin
		cfg_word                     = 32'h00000000;
		cfg_word[`SPR_CFG_BCAST_BIT] = bcast_filter_on;
		cfg_word[`SPR_CFG_CHAN_BIT]  = channel_on;
		cfg_word[`SPR_CFG_TX_BIT]    = tx_on;
		cfg_word[`SPR_CFG_MCAST_BIT] = mcast_filter_on;
	end

	// ------------------------------------------------------------------
	// Next response
	// ------------------------------------------------------------------
	// Every field is computed from the same cycle's inputs and loads on
	// the same edge, so no response mixes values from either side of a
	// configuration change.
	reg                     next_rsp_valid;
	reg  [7:0]              next_rsp_type;
	reg  [7:0]              next_rsp_mac_count;
	reg  [7:0]              next_rsp_tag_count;
	reg  [7:0]              next_rsp_mac_flags;
	reg  [15:0]             next_rsp_tag_flags;
	reg  [31:0]             next_rsp_link;
	reg  [31:0]             next_rsp_bcast;
	reg  [31:0]             next_rsp_cfg_flags;
	reg  [8*48-1:0]         next_rsp_macs;
	reg  [15*16-1:0]        next_rsp_tags;
	reg  [NUM_STATS*32-1:0] next_rsp_stats;

	// Fields hold between responses; a refused command leaves them alone.
	always @* begin
		next_rsp_valid     = 1'b0;
		next_rsp_type      = rsp_type;
		next_rsp_mac_count = rsp_mac_count;
		next_rsp_tag_count = rsp_tag_count;
		next_rsp_mac_flags = rsp_mac_flags;
		next_rsp_tag_flags = rsp_tag_flags;
		next_rsp_link      = rsp_link;
		next_rsp_bcast     = rsp_bcast;
		next_rsp_cfg_flags = rsp_cfg_flags;
		next_rsp_macs      = rsp_macs;
		next_rsp_tags      = rsp_tags;
		next_rsp_stats     = rsp_stats;
		case (cmd_kind)
			KIND_PARAMS: begin
				next_rsp_valid     = 1'b1;
				next_rsp_type      = `SPR_RSP_GET_PARAMS;
				next_rsp_mac_count = MAC_TOTAL[7:0];
				next_rsp_tag_count = TAG_COUNT[7:0];
				next_rsp_mac_flags = addr_filter_enable_bits & mac_mask;
				next_rsp_tag_flags = tag_filter_enable_bits & tag_mask;
				next_rsp_link      = link_settings;
				next_rsp_bcast     = bcast_settings;
				next_rsp_cfg_flags = cfg_word;
				// Input slots already run unicast, multicast, mixed.
				next_rsp_macs      = mac_values & mac_vmask;
				next_rsp_tags      = tag_values & tag_vmask;
			end
			KIND_STATS: begin
				next_rsp_valid     = 1'b1;
				next_rsp_type      = `SPR_RSP_GET_STATS;
				next_rsp_stats     = stat_bus;
			end
			default: begin
				next_rsp_valid     = 1'b0;
			end
		endcase
	end

	// ------------------------------------------------------------------
	// Response registers
	// ------------------------------------------------------------------
	// A low clock enable freezes the whole response, the pulse included.
	always @(posedge clock) begin
		if (rst) begin
			rsp_valid     <= 1'b0;
			rsp_type      <= 8'h00;
			rsp_mac_count <= 8'h00;
			rsp_tag_count <= 8'h00;
			rsp_mac_flags <= 8'h00;
			rsp_tag_flags <= 16'h0000;
			rsp_link      <= 32'h00000000;
			rsp_bcast     <= 32'h00000000;
			rsp_cfg_flags <= 32'h00000000;
			rsp_macs      <= {8*48{1'b0}};
			rsp_tags      <= {15*16{1'b0}};
			rsp_stats     <= {NUM_STATS*32{1'b0}};
		end else if (clock_en) begin
			rsp_valid     <= next_rsp_valid;
			rsp_type      <= next_rsp_type;
			rsp_mac_count <= next_rsp_mac_count;
			rsp_tag_count <= next_rsp_tag_count;
			rsp_mac_flags <= next_rsp_mac_flags;
			rsp_tag_flags <= next_rsp_tag_flags;
			rsp_link      <= next_rsp_link;
			rsp_bcast     <= next_rsp_bcast;
			rsp_cfg_flags <= next_rsp_cfg_flags;
			rsp_macs      <= next_rsp_macs;
			rsp_tags      <= next_rsp_tags;
			rsp_stats     <= next_rsp_stats;
		end
	end
endmodule // spr_responder

// ==== tb/spr_asserts.sv ====
`timescale 1ns/1ps
// ------
// Response checks
// ------
module spr_asserts (
	// Clock and command
	input wire        clock,
	input wire        rst,
	input wire        clock_en,
	input wire        cmd_valid,
	input wire [7:0]  cmd_type,
	input wire        cmd_chk_err,
	input wire        cmd_id_err,
	// Configuration
	input wire [7:0]  addr_filter_enable_bits,
	input wire [15:0] tag_filter_enable_bits,
	input wire [31:0] link_settings,
	input wire [31:0] bcast_settings,
	input wire        bcast_filter_on,
	input wire        channel_on,
	input wire        tx_on,
	input wire        mcast_filter_on,
	// Response
	input wire        rsp_valid,
	input wire [7:0]  rsp_type,
	input wire [7:0]  rsp_mac_flags,
	input wire [15:0] rsp_tag_flags,
	input wire [31:0] rsp_link,
	input wire [31:0] rsp_bcast,
	input wire [31:0] rsp_cfg_flags
);
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	wire ok = cmd_valid && clock_en && !cmd_chk_err && !cmd_id_err;
	sequence s_par; ok && cmd_type == 8'h17; endsequence
	sequence s_sta; ok && cmd_type == 8'h18; endsequence
	property p_ack; (s_par or s_sta) |=> rsp_valid; endproperty
	a_ack: assert property (p_ack) else $error("no answer");
	property p_ref; cmd_valid && clock_en && (cmd_chk_err || cmd_id_err)
		|=> !rsp_valid;
	endproperty
	a_ref: assert property (p_ref) else $error("bad command answered");
	property p_sta; s_sta |=> rsp_type == 8'h98; endproperty
	a_sta: assert property (p_sta) else $error("stats type");
	property p_lnk; s_par |=> rsp_link == $past(link_settings); endproperty
	a_lnk: assert property (p_lnk) else $error("link field");
	property p_bc; s_par |=> rsp_bcast == $past(bcast_settings); endproperty
	a_bc: assert property (p_bc) else $error("broadcast field");
	property p_cfg; s_par |=> rsp_cfg_flags == {28'h0, $past(mcast_filter_on),
		$past(tx_on), $past(channel_on), $past(bcast_filter_on)};
	endproperty
	a_cfg: assert property (p_cfg) else $error("config flags");
	property p_flg;
		s_par |=> (rsp_mac_flags & ~$past(addr_filter_enable_bits)) == 8'h0;
	endproperty
	a_flg: assert property (p_flg) else $error("filter flags");
	property p_tfl;
		s_par |=> (rsp_tag_flags & ~$past(tag_filter_enable_bits)) == 16'h0;
	endproperty
	a_tfl: assert property (p_tfl) else $error("tag flags");
	property p_hold; !rsp_valid |-> $stable(rsp_link); endproperty
	a_hold: assert property (p_hold) else $error("field moved");
	property p_src;
		rsp_valid && $past(clock_en) |-> $past(cmd_valid);
	endproperty
	a_src: assert property (p_src) else $error("spurious answer");
endmodule // spr_asserts
bind spr_responder spr_asserts i_chk (.*);

// ==== tb/spr_mc_model.sv ====
`timescale 1ns/1ps
// ------
// Management controller, one command per call
// ------
module spr_mc_model (
	// Clock
	input  wire       clock,
	// Command lines
	output reg        cmd_valid,
	output reg  [7:0] cmd_type,
	output reg        cmd_chk_err,
	output reg        cmd_id_err
);
	initial {cmd_valid, cmd_type, cmd_chk_err, cmd_id_err} = 11'h0;
	// Idle lines carry inverted values so stale codes are never trusted.
	task send(input [7:0] t, input ce, input ie);
		begin
			@(posedge clock);
			cmd_valid <= 1'b1;
			cmd_type <= t;
			cmd_chk_err <= ce;
			cmd_id_err <= ie;
			@(posedge clock);
			cmd_valid <= 1'b0;
			cmd_type <= ~t;
			cmd_chk_err <= ~ce;
			cmd_id_err <= ~ie;
			#1;
		end
	endtask
endmodule // spr_mc_model

// ==== tb/sideband_param_stats_response_tb.sv ====
`timescale 1ns/1ps
module sideband_param_stats_response_tb;
	reg clock = 1'b0, rst = 1'b1, clock_en = 1'b1;
	reg [7:0] addr_filter_enable_bits = 8'h0;
	reg [15:0] tag_filter_enable_bits = 16'h0;
	reg [31:0] link_settings = 32'h0, bcast_settings = 32'h0;
	reg bcast_filter_on = 0, channel_on = 0, tx_on = 0, mcast_filter_on = 0;
	reg [383:0] mac_values;
	reg [239:0] tag_values;
	reg [63:0] host_inc = 64'h0, pass_inc = 64'h0;
	wire cmd_valid, cmd_chk_err, cmd_id_err, rsp_valid;
	wire [7:0] cmd_type, rsp_type, rsp_mac_count, rsp_tag_count, rsp_mac_flags;
	wire [15:0] rsp_tag_flags;
	wire [31:0] rsp_link, rsp_bcast, rsp_cfg_flags;
	wire [383:0] rsp_macs;
	wire [239:0] rsp_tags;
	wire [127:0] rsp_stats;
	integer n_errors = 0, n_checks = 0, i;
	spr_responder i_dut (.*);
	spr_mc_model i_mc (.*);
	initial forever #2 clock = ~clock;
	task chk(input [383:0] seen, input [383:0] exp);
		begin
			n_checks = n_checks + 1;
			if (seen !== exp) begin
				n_errors = n_errors + 1;
				$display("ERROR %0t seen %0h expected %0h", $time, seen, exp);
			end
		end
	endtask
	task give_verdict;
		begin
			$display("checks %0d errors %0d", n_checks, n_errors);
			if (n_errors == 0 && n_checks > 0)
				$display("ALL CHECKS OK");
			else
				$display("CHECKS NOT OK");
			$finish;
		end
	endtask
	initial begin
		for (i = 0; i < 15; i = i + 1) begin
			mac_values[48*(i%8)+:48] = {40'hC0FFEE1234, i[7:0]};
			tag_values[16*i+:16] = {8'h5A, i[7:0]};
		end
		repeat (3) @(posedge clock);
		rst <= 1'b0;
		link_settings <= 32'h12345678;
		bcast_settings <= 32'h0000000D;
		{mcast_filter_on, tx_on, channel_on, bcast_filter_on} <= 4'hA;
		addr_filter_enable_bits <= 8'hE5;
		tag_filter_enable_bits <= 16'hFFF9;
		i_mc.send(8'h17, 1'b0, 1'b0);
		chk({rsp_valid, rsp_type}, 9'h197);
		chk({rsp_mac_count, rsp_tag_count}, 16'h0604);
		chk({rsp_mac_flags, rsp_tag_flags}, 24'h250009);
		chk(rsp_cfg_flags, 32'hA);
		chk({rsp_link, rsp_bcast}, 64'h123456780000000D);
		chk(rsp_macs, {96'h0, mac_values[287:0]});
		chk(rsp_tags, tag_values[63:0]);
		@(posedge clock);
		link_settings <= 32'h0;
		host_inc <= 64'h0003000200010000;
		pass_inc <= {4{16'h0010}};
		repeat (5) @(posedge clock);
		host_inc <= 64'h0;
		pass_inc <= 64'h0;
		chk(rsp_link, 32'h12345678);
		for (i = 0; i < 3; i = i + 1) begin
			i_mc.send(i == 2 ? 8'h20 : 8'h18, i == 0, i == 1);
			chk(rsp_valid, 1'b0);
		end
		i_mc.send(8'h18, 1'b0, 1'b0);
		chk({rsp_valid, rsp_type}, 9'h198);
		chk(rsp_stats, {32'hFFFFFFFF, 32'h5A, 32'h55, 32'h50});
		chk(rsp_link, 32'h12345678);
		// Commands and traffic while the enable is low must leave no trace.
		@(posedge clock);
		clock_en <= 1'b0;
		host_inc <= {4{16'h0001}};
		{mcast_filter_on, tx_on, channel_on, bcast_filter_on} <= 4'h5;
		i_mc.send(8'h17, 1'b0, 1'b0);
		chk({rsp_valid, rsp_type}, 9'h098);
		@(posedge clock);
		clock_en <= 1'b1;
		host_inc <= 64'h0;
		i_mc.send(8'h17, 1'b0, 1'b0);
		chk({rsp_valid, rsp_type}, 9'h197);
		chk({rsp_cfg_flags, rsp_link}, 64'h0000000500000000);
		i_mc.send(8'h18, 1'b0, 1'b0);
		chk(rsp_stats, {32'hFFFFFFFF, 32'h5A, 32'h55, 32'h50});
		// A second reset mid-run clears the counters and every field.
		@(posedge clock);
		rst <= 1'b1;
		repeat (3) @(posedge clock);
		rst <= 1'b0;
		i_mc.send(8'h18, 1'b0, 1'b0);
		chk({rsp_valid, rsp_type}, 9'h198);
		chk(rsp_stats, {32'hFFFFFFFF, 96'h0});
		chk({rsp_cfg_flags, rsp_mac_flags}, 40'h0);
		give_verdict;
	end
endmodule // sideband_param_stats_response_tb
